// ==== ccsr_bank.sv ====
// attribute-space configuration and status register bank of the card
`timescale 1ns/1ps
`include "ccsr_regs.svh"
module ccsr_bank (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic reg_sel_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire ccsr_pkg::ccsr_addr_t reg_addr_in,
	input wire ccsr_pkg::ccsr_byte_t reg_wdata_in,
	input wire logic io_mode_in,
	input wire logic true_ide_in,
	input wire logic int_request_in,
	input wire logic interrupt_disable_in,
	input wire logic ready_busy_in,
	input wire logic write_protect_in,
	output ccsr_pkg::ccsr_byte_t reg_rdata_out,
	output logic reg_rvalid_out,
	output logic status_change_pin_n_out,
	output logic power_down_out,
	output logic io_8bit_only_out,
	output logic [0:0] card_copy_number_out
);
	import ccsr_pkg::*;

	ccsr_sync_if sync_bus ();
	ccsr_sync u_sync (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.clk_en_in(clk_en_in),
		.ready_in(ready_busy_in),
		.wprot_in(write_protect_in),
		.sync(sync_bus.producer)
	);

	logic status_change_enable;
	logic io_8bit_only;
	ccsr_power_e power_state;
	logic ready_change_latch;
	logic write_protect_change;
	logic card_copy_number;
	logic ready_prev;
	logic wprot_prev;
	logic int_sync_meta;
	logic int_sync;
	logic dis_sync_meta;
	logic dis_sync;
	logic [1:0] sync_warm;

	// no access at all in True IDE mode
	wire access_ok = reg_sel_in && !true_ide_in;
	wire hit_cs = reg_addr_in == `CCSR_OFF_CFG_STATUS;
	wire hit_pr = reg_addr_in == `CCSR_OFF_PIN_REPL;
	wire hit_sc = reg_addr_in == `CCSR_OFF_SOCK_COPY;
	// [R14] mode gating
	wire wr_cs = access_ok && reg_wr_in && hit_cs;
	wire wr_pr = access_ok && reg_wr_in && hit_pr;
	wire wr_sc = access_ok && reg_wr_in && hit_sc;
	wire rd_any = access_ok && reg_rd_in;

	// [R10] live ready state
	wire ready_now = sync_bus.ready;
	// [R11] live write protect
	wire wprot_now = sync_bus.wprot;
	// synchronisers restart from zero: a pin already high is no change
	wire sync_settled = sync_warm == `CCSR_SYNC_SETTLE;
	// [R08] ready edge detect
	wire ready_edge = sync_settled && (ready_now != ready_prev);
	// [R09] protect edge detect
	wire wprot_edge = sync_settled && (wprot_now != wprot_prev);
	// [R06] [R07] masked interrupt view
	wire interrupt_pending = int_sync && !dis_sync;
	// [R01] mirror of the latch
	wire status_changed = ready_change_latch;

	// a latch event beats a host write of zero in the same cycle
	wire next_ready_change = ready_edge ? 1'b1 :
		(wr_pr ? reg_wdata_in[`CCSR_BIT_RDYCHG] : ready_change_latch);
	wire next_wprot_change = wprot_edge ? 1'b1 :
		(wr_pr ? reg_wdata_in[`CCSR_BIT_WPCHG] : write_protect_change);

	function automatic ccsr_byte_t bit_at(input logic v, input int pos);
		ccsr_byte_t b;
		b = 8'h00;
		b[pos[2:0]] = v;
		return b;
	endfunction

	wire ccsr_byte_t cs_view = bit_at(status_changed, `CCSR_BIT_STATUS_CHANGED)
		| bit_at(status_change_enable, `CCSR_BIT_SIGEN)
		| bit_at(io_8bit_only, `CCSR_BIT_IO8)
		| bit_at(power_state == CCSR_SLEEP, `CCSR_BIT_PWD)
		| bit_at(interrupt_pending, `CCSR_BIT_INTERRUPT_PENDING);
	wire ccsr_byte_t pr_view = `CCSR_PIN_REPL_ONES
		| bit_at(ready_change_latch, `CCSR_BIT_RDYCHG)
		| bit_at(write_protect_change, `CCSR_BIT_WPCHG)
		| bit_at(ready_now, `CCSR_BIT_RDY)
		| bit_at(wprot_now, `CCSR_BIT_WP);
	wire ccsr_byte_t sc_view = `CCSR_SOCK_COPY_ONES | bit_at(card_copy_number, `CCSR_BIT_COPY);
	wire ccsr_byte_t next_rdata = hit_cs ? cs_view : hit_pr ? pr_view : hit_sc ? sc_view : 8'h00;

	// [R02] [R03] status change pin drive, only in I/O mode
	wire next_status_change_pin_n = !(io_mode_in && status_change_enable && status_changed);

	// interrupt request and disable come from another block: synchronise to be safe
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			int_sync_meta <= 1'b0;
			int_sync <= 1'b0;
			dis_sync_meta <= 1'b0;
			dis_sync <= 1'b0;
		end else if (clk_en_in) begin
			int_sync_meta <= int_request_in;
			int_sync <= int_sync_meta;
			dis_sync_meta <= interrupt_disable_in;
			dis_sync <= dis_sync_meta;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			status_change_enable <= 1'b0;
			io_8bit_only <= 1'b0;
			power_state <= CCSR_ACTIVE;
		end else if (clk_en_in && wr_cs) begin
			status_change_enable <= reg_wdata_in[`CCSR_BIT_SIGEN];
			// [R04] host byte-lane option
			io_8bit_only <= reg_wdata_in[`CCSR_BIT_IO8];
			// [R05] sleep or idle
			power_state <= reg_wdata_in[`CCSR_BIT_PWD] ? CCSR_SLEEP : CCSR_ACTIVE;
		end
	end

	// pin replacement reset value leaves both latches clear
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ready_change_latch <= 1'b0;
			write_protect_change <= 1'b0;
			ready_prev <= 1'b0;
			wprot_prev <= 1'b0;
			sync_warm <= 2'h0;
		end else if (clk_en_in) begin
			ready_change_latch <= next_ready_change;
			write_protect_change <= next_wprot_change;
			ready_prev <= ready_now;
			wprot_prev <= wprot_now;
			// limitation: a real change in the first cycles after reset is not latched
			if (!sync_settled) begin
				sync_warm <= sync_warm + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			card_copy_number <= 1'b0;
		// [R13] keep copy number
		end else if (clk_en_in && wr_sc) begin
			card_copy_number <= reg_wdata_in[`CCSR_BIT_COPY];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
			status_change_pin_n_out <= 1'b1;
			power_down_out <= 1'b0;
			io_8bit_only_out <= 1'b0;
			card_copy_number_out <= 1'b0;
		end else if (clk_en_in) begin
			reg_rdata_out <= rd_any ? next_rdata : 8'h00;
			reg_rvalid_out <= rd_any;
			status_change_pin_n_out <= next_status_change_pin_n;
			power_down_out <= power_state == CCSR_SLEEP;
			io_8bit_only_out <= io_8bit_only;
			card_copy_number_out <= card_copy_number;
		end
	end

	// [R03] pin high when enable clear
	status_change_pin_idle_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R03]
		clk_en_in && !status_change_enable |=> status_change_pin_n_out)
		else $error("status change pin low with enable clear");
	// [R02] pin low when changed and enabled
	status_change_pin_low_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R02]
		clk_en_in && io_mode_in && status_change_enable && ready_change_latch
		|=> !status_change_pin_n_out)
		else $error("status change pin not driven low");
	// [R08] ready change sets latch
	rdy_latch_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R08]
		clk_en_in && ready_edge |=> ready_change_latch)
		else $error("ready change not latched");
	// [R09] protect change sets latch
	wp_latch_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R09]
		clk_en_in && wprot_edge |=> write_protect_change)
		else $error("write protect change not latched");
	// [R05] power down follows write
	pwd_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R05]
		clk_en_in && wr_cs ##1 clk_en_in |=>
		power_down_out == $past(reg_wdata_in[`CCSR_BIT_PWD], 2))
		else $error("power down output does not follow write");
	// [R14] no reads in ide mode
	ide_block_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R14]
		clk_en_in && true_ide_in |=> !reg_rvalid_out)
		else $error("register read answered in true ide mode");
	// [R07] masked interrupt reads zero
	interrupt_pending_mask_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R07]
		clk_en_in && rd_any && hit_cs && dis_sync |=> !reg_rdata_out[`CCSR_BIT_INTERRUPT_PENDING])
		else $error("interrupt pending visible while disabled");
	// [R13] copy number retained
	copy_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R13]
		clk_en_in && wr_sc ##1 clk_en_in |=>
		card_copy_number_out == $past(reg_wdata_in[`CCSR_BIT_COPY], 2))
		else $error("copy number not kept");
	// [R01] status changed mirrors latch
	status_changed_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R01]
		clk_en_in && rd_any && hit_cs |=>
		reg_rdata_out[`CCSR_BIT_STATUS_CHANGED] == $past(ready_change_latch))
		else $error("status changed bit differs from latch");
endmodule // ccsr_bank

// ==== ccsr_regs.svh ====
// register offsets, field positions and reset values of the card configuration registers
// Contract
// [R01] status_changed reads back whether the ready-change latch currently holds one.
// [R02] in I/O mode the status change pin is driven low when status_changed and its enable are set.
// [R03] in I/O mode with the enable clear the status change pin stays high.
// [R04] the host sets io_8bit_only when it can only use the low data byte; the bit is read/write.
// [R05] writing one to power_down_request sends the card to sleep, zero returns it to idle.
// [R06] interrupt_pending follows the internal interrupt request in any interface mode.
// [R07] interrupt_pending reads zero while interrupt_disable is set.
// [R08] the ready-change latch is set whenever ready_busy_state changes; the host may write it. Code ignores the first 3 cycles after reset.
// [R09] the write-protect-change latch is set whenever write_protect_state changes; host may write it. Code ignores the first 3 cycles after reset.
// [R10] ready_busy_state shows the internal ready/busy signal.
// [R11] write_protect_state reads one when the card is write protected.
// [R12] the host programs socket_and_copy before the configuration option register.
// [R13] the card keeps the copy number the host writes into socket_and_copy.
// [R14] these registers are reachable only in memory and I/O modes, never in True IDE mode.
`ifndef CCSR_REGS_SVH
`define CCSR_REGS_SVH
`define CCSR_OFF_CFG_STATUS 11'h202
`define CCSR_OFF_PIN_REPL 11'h204
`define CCSR_OFF_SOCK_COPY 11'h206
`define CCSR_RST_CFG_STATUS 8'h00
`define CCSR_RST_PIN_REPL 8'h0c
`define CCSR_RST_SOCK_COPY 8'h00
`define CCSR_BIT_STATUS_CHANGED 7
`define CCSR_BIT_SIGEN 6
`define CCSR_BIT_IO8 5
`define CCSR_BIT_PWD 2
`define CCSR_BIT_INTERRUPT_PENDING 1
`define CCSR_BIT_RDYCHG 5
`define CCSR_BIT_WPCHG 4
`define CCSR_BIT_RDY 1
`define CCSR_BIT_WP 0
`define CCSR_BIT_COPY 4
`define CCSR_PIN_REPL_ONES 8'h0c
`define CCSR_SOCK_COPY_ONES 8'h0c
`define CCSR_SYNC_SETTLE 2'h3
`endif

// ==== ccsr_pkg.sv ====
// types shared by the card configuration register bank
package ccsr_pkg;
	typedef logic [7:0] ccsr_byte_t;
	typedef logic [10:0] ccsr_addr_t;
	typedef enum logic [1:0] {
		CCSR_ACTIVE = 2'b01,
		CCSR_SLEEP = 2'b10
	} ccsr_power_e;
endpackage

// ==== ccsr_sync_if.sv ====
// carrier for the pin-level status inputs after synchronisation
`timescale 1ns/1ps
interface ccsr_sync_if;
	logic ready;
	logic wprot;
	modport producer (output ready, output wprot);
	modport consumer (input ready, input wprot);
endinterface

// ==== ccsr_sync.sv ====
// two-flop synchronisers for the ready/busy and write-protect levels
`timescale 1ns/1ps
module ccsr_sync (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic ready_in,
	input wire logic wprot_in,
	ccsr_sync_if.producer sync
);
	logic [1:0] meta;
	logic [1:0] stable;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			meta <= 2'h0;
			stable <= 2'h0;
		end else if (clk_en_in) begin
			meta <= {ready_in, wprot_in};
			stable <= meta;
		end
	end
	assign sync.ready = stable[1];
	assign sync.wprot = stable[0];
endmodule // ccsr_sync

// ==== ccsr_host.sv ====
// host socket controller model issuing attribute register cycles
`timescale 1ns/1ps
module ccsr_host (
	input wire logic core_clk_in,
	input wire ccsr_pkg::ccsr_byte_t rdata_in,
	input wire logic rvalid_in,
	output logic sel_out,
	output logic wr_out,
	output logic rd_out,
	output ccsr_pkg::ccsr_addr_t addr_out,
	output ccsr_pkg::ccsr_byte_t wdata_out
);
	import ccsr_pkg::*;
	initial begin
		sel_out = 1'b0;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 11'h7ff;
		wdata_out = 8'haa;
	end
	// host register writes and reads
	// released lines show inverted values so stale data never looks valid
	task automatic wr_reg(input ccsr_addr_t a, input ccsr_byte_t d);
		@(posedge core_clk_in);
		sel_out <= 1'b1;
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge core_clk_in);
		sel_out <= 1'b0;
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic rd_reg(input ccsr_addr_t a, output ccsr_byte_t d, output logic v);
		@(posedge core_clk_in);
		sel_out <= 1'b1;
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge core_clk_in);
		sel_out <= 1'b0;
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule // ccsr_host

// ==== tb_top.sv ====
// self-checking bench for the card configuration register bank
`timescale 1ns/1ps
`include "ccsr_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
	import ccsr_pkg::*;
	logic core_clk_in = 1'b0;
	logic reset_in, clk_en_in, io_mode_in, true_ide_in, int_request_in;
	logic interrupt_disable_in, ready_busy_in, write_protect_in;
	logic reg_sel_in, reg_wr_in, reg_rd_in, reg_rvalid_out, status_change_pin_n_out;
	logic power_down_out, io_8bit_only_out;
	logic [0:0] card_copy_number_out;
	ccsr_addr_t reg_addr_in;
	ccsr_byte_t reg_wdata_in, reg_rdata_out;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	always #25 core_clk_in = ~core_clk_in;
	ccsr_bank i_ccsr_bank (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.clk_en_in(clk_en_in), .reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.io_mode_in(io_mode_in), .true_ide_in(true_ide_in), .int_request_in(int_request_in),
		.interrupt_disable_in(interrupt_disable_in), .ready_busy_in(ready_busy_in),
		.write_protect_in(write_protect_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .status_change_pin_n_out(status_change_pin_n_out),
		.power_down_out(power_down_out), .io_8bit_only_out(io_8bit_only_out),
		.card_copy_number_out(card_copy_number_out));
	ccsr_host i_ccsr_host (.core_clk_in(core_clk_in), .rdata_in(reg_rdata_out),
		.rvalid_in(reg_rvalid_out), .sel_out(reg_sel_in), .wr_out(reg_wr_in),
		.rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
	task automatic print_verdict;
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// tests need about 120 cycles; a hang stops here
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			print_verdict;
		end
	end
	task automatic rd_chk(input ccsr_addr_t a, input ccsr_byte_t e);
		ccsr_byte_t d;
		logic v;
		i_ccsr_host.rd_reg(a, d, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("rdata", e, d)
	endtask
	task automatic wr_wait(input ccsr_addr_t a, input ccsr_byte_t d);
		i_ccsr_host.wr_reg(a, d);
		repeat (2) @(posedge core_clk_in);
		#1;
	endtask
	task automatic t_reset;
		rd_chk(`CCSR_OFF_CFG_STATUS, `CCSR_RST_CFG_STATUS);
		rd_chk(`CCSR_OFF_PIN_REPL, `CCSR_RST_PIN_REPL);
		rd_chk(`CCSR_OFF_SOCK_COPY, `CCSR_SOCK_COPY_ONES);
		rd_chk(11'h200, 8'h00);
		`CHK("pin_n", 1'b1, status_change_pin_n_out)
		`CHK("power_down", 1'b0, power_down_out)
	endtask
	task automatic t_config;
		wr_wait(`CCSR_OFF_CFG_STATUS, 8'hff);
		`CHK("power_down", 1'b1, power_down_out)
		`CHK("io8", 1'b1, io_8bit_only_out)
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'h64);
		wr_wait(`CCSR_OFF_CFG_STATUS, 8'h00);
		`CHK("power_down", 1'b0, power_down_out)
	endtask
	task automatic t_latch;
		@(posedge core_clk_in);
		io_mode_in <= 1'b1;
		ready_busy_in <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		rd_chk(`CCSR_OFF_PIN_REPL, 8'h2e);
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'h80);
		`CHK("pin_n", 1'b1, status_change_pin_n_out)
		wr_wait(`CCSR_OFF_CFG_STATUS, 8'h40);
		`CHK("pin_n", 1'b0, status_change_pin_n_out)
		@(posedge core_clk_in);
		io_mode_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		#1;
		`CHK("pin_n", 1'b1, status_change_pin_n_out)
		@(posedge core_clk_in);
		io_mode_in <= 1'b1;
		wr_wait(`CCSR_OFF_PIN_REPL, 8'h00);
		`CHK("pin_n", 1'b1, status_change_pin_n_out)
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'h40);
		@(posedge core_clk_in);
		write_protect_in <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		rd_chk(`CCSR_OFF_PIN_REPL, 8'h1f);
		wr_wait(`CCSR_OFF_PIN_REPL, 8'h20);
		rd_chk(`CCSR_OFF_PIN_REPL, 8'h2f);
		`CHK("pin_n", 1'b0, status_change_pin_n_out)
	endtask
	task automatic t_interrupt_pending;
		@(posedge core_clk_in);
		int_request_in <= 1'b1;
		io_mode_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'hc2);
		@(posedge core_clk_in);
		interrupt_disable_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'hc0);
	endtask
	task automatic t_copy_ide;
		ccsr_byte_t d;
		logic v;
		wr_wait(`CCSR_OFF_SOCK_COPY, 8'h10);
		`CHK("copy", 1'b1, card_copy_number_out)
		rd_chk(`CCSR_OFF_SOCK_COPY, 8'h1c);
		@(posedge core_clk_in);
		true_ide_in <= 1'b1;
		wr_wait(`CCSR_OFF_SOCK_COPY, 8'h00);
		i_ccsr_host.rd_reg(`CCSR_OFF_SOCK_COPY, d, v);
		`CHK("ide_rvalid", 1'b0, v)
		@(posedge core_clk_in);
		true_ide_in <= 1'b0;
		rd_chk(`CCSR_OFF_SOCK_COPY, 8'h1c);
	endtask
	task automatic t_freeze;
		@(posedge core_clk_in);
		clk_en_in <= 1'b0;
		wr_wait(`CCSR_OFF_CFG_STATUS, 8'h04);
		`CHK("frozen_pwd", 1'b0, power_down_out)
		@(posedge core_clk_in);
		clk_en_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		#1;
		`CHK("frozen_pwd", 1'b0, power_down_out)
		rd_chk(`CCSR_OFF_CFG_STATUS, 8'hc0);
	endtask
	task automatic t_rerst;
		wr_wait(`CCSR_OFF_CFG_STATUS, 8'h24);
		`CHK("io8", 1'b1, io_8bit_only_out)
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'b0;
		@(posedge core_clk_in);
		#1;
		`CHK("power_down", 1'b0, power_down_out)
		`CHK("io8", 1'b0, io_8bit_only_out)
		`CHK("copy", 1'b0, card_copy_number_out)
		`CHK("pin_n", 1'b1, status_change_pin_n_out)
		`CHK("rvalid", 1'b0, reg_rvalid_out)
		repeat (4) @(posedge core_clk_in);
		rd_chk(`CCSR_OFF_PIN_REPL, 8'h0f);
		rd_chk(`CCSR_OFF_CFG_STATUS, `CCSR_RST_CFG_STATUS);
	endtask
	initial begin
		reset_in = 1'b1;
		clk_en_in = 1'b1;
		io_mode_in = 1'b0;
		true_ide_in = 1'b0;
		int_request_in = 1'b0;
		interrupt_disable_in = 1'b0;
		ready_busy_in = 1'b0;
		write_protect_in = 1'b0;
		repeat (8) @(posedge core_clk_in);
		reset_in <= 1'b0;
		t_reset;
		t_config;
		t_latch;
		t_interrupt_pending;
		t_copy_ide;
		t_freeze;
		t_rerst;
		print_verdict;
	end
endmodule // tb_top
